/* logic/sft_pkg.sv */
// package of constants and types for the serial flag transfer logic
// Function
// - transfer-controller write serving tx request clears tx_data_empty_flag automatically.
// - transfer-controller read serving rx request clears rx_data_full_flag automatically.
// - receive-error request never starts a transfer-controller transfer.
// - auto clearing only when disable select is 0 and counter nonzero.
// - after reset module stopped; registers accessible only after stop bit cleared.
// - tx_end_flag bit 2 clears on write 0 or controller write of tx_data_reg.
// - guard_time_mode 0: tx_end_flag set 12.5 etu after character if empty, no error.
// - guard_time_mode 1: tx_end_flag set 11.0 etu after character if empty, no error.
package sft_pkg;
    // ====================================================================
    // register offsets (byte addresses)
    localparam logic [7:0] SFT_OFF_TXDATA  = 8'h00;
    localparam logic [7:0] SFT_OFF_RXDATA  = 8'h04;
    localparam logic [7:0] SFT_OFF_STATUS  = 8'h08;
    localparam logic [7:0] SFT_OFF_MODE    = 8'h0c;
    localparam logic [7:0] SFT_OFF_CTRL    = 8'h10;
    localparam logic [7:0] SFT_OFF_IRQSTAT = 8'h14;
    localparam logic [7:0] SFT_OFF_IRQMASK = 8'h18;
    localparam logic [7:0] SFT_OFF_STOP    = 8'h1c;
    // ====================================================================
    // status bit positions
    localparam int SFT_BIT_TDE  = 7;
    localparam int SFT_BIT_RDF  = 6;
    localparam int SFT_BIT_ORER = 5;
    localparam int SFT_BIT_ERS  = 4;
    localparam int SFT_BIT_TX_END_FLAG = 2;
    // mode / control bit positions
    localparam int SFT_BIT_GM   = 7;
    localparam int SFT_BIT_CKE0 = 0;
    // irq status bits
    localparam int SFT_IRQ_TXI  = 0;
    localparam int SFT_IRQ_RXI  = 1;
    localparam int SFT_IRQ_ERI  = 2;
    localparam int SFT_IRQ_TEI  = 3;
    // ====================================================================
    // reset values and timing
    localparam logic [7:0] SFT_STATUS_RST = 8'h84;
    localparam logic [7:0] SFT_MODE_RST   = 8'h00;
    localparam logic [7:0] SFT_CTRL_RST   = 8'h00;
    localparam logic       SFT_STOP_RST   = 1'b1;
    localparam int SFT_ETU_HALF_GM0 = 25;  // 12.5 etu in half units
    localparam int SFT_ETU_HALF_GM1 = 22;  // 11.0 etu in half units
    localparam int SFT_ETU_DIV_DEF  = 372;
    localparam int SFT_HALF_W       = 5;

    typedef struct packed {
        logic       req;
        logic       xfer_irq_disable_select;
        logic       cnt_nz;
        logic       wr;
        logic [7:0] addr;
    } sft_dtc_s;
endpackage : sft_pkg

/* logic/sft_flags.sv */
// serial interface status-flag logic behind an apb slave
module sft_flags
    import sft_pkg::*;
#(
    parameter int ETU_DIV = SFT_ETU_DIV_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire sft_dtc_s    dtc_in,
    output logic             dtc_ack,
    input  wire logic        tx_char_done,
    input  wire logic        rx_char_done,
    input  wire logic [7:0]  rx_char,
    input  wire logic        rx_error,
    input  wire logic        error_signal_in,
    output logic             tx_data_valid,
    output logic      [7:0]  tx_data_out,
    output logic             tx_empty_irq,
    output logic             rx_full_irq,
    output logic             rx_error_irq,
    output logic             dtc_req_tx,
    output logic             dtc_req_rx,
    output logic             irq
);
    // ====================================================================
    // parameter check: an odd divider cannot give an exact half etu
    if (ETU_DIV < 2 || ETU_DIV > 65535 || (ETU_DIV % 2) != 0) begin : g_bad_div
        $error("ETU_DIV must be even and between 2 and 65535");
    end

    // ====================================================================
    // registers
    logic [7:0]            tx_data_reg_r;
    logic [7:0]            rx_data_reg_r;
    logic [7:0]            mode_r;
    logic [7:0]            ctrl_r;
    logic                  tde_r;
    logic                  rdf_r;
    logic                  tx_end_flag_r;
    logic                  ers_r;
    logic                  orer_r;
    logic                  stop_r;
    logic [3:0]            irq_stat_r;
    logic [3:0]            irq_mask_r;
    logic [31:0]           prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;
    logic                  dtc_ack_r;
    logic                  irq_r;
    logic                  tx_valid_r;
    logic [15:0]           div_r;
    logic [SFT_HALF_W-1:0] half_r;
    logic                  tx_end_flag_run_r;
    logic                  err_s1_r;
    logic                  err_s2_r;

    // ====================================================================
    // decode
    wire setup     = psel && !penable;
    wire acc       = psel && penable && pready_r;
    wire stop_sel  = paddr == SFT_OFF_STOP;
    wire blocked   = stop_r && !stop_sel;
    wire known     = paddr == SFT_OFF_TXDATA || paddr == SFT_OFF_RXDATA ||
                     paddr == SFT_OFF_STATUS || paddr == SFT_OFF_MODE ||
                     paddr == SFT_OFF_CTRL || paddr == SFT_OFF_IRQSTAT ||
                     paddr == SFT_OFF_IRQMASK || stop_sel;
    wire wr_ok     = acc && pwrite && known && !blocked;
    wire rd_ok     = acc && !pwrite && known && !blocked;
    wire wr_tdr    = wr_ok && paddr == SFT_OFF_TXDATA;
    wire wr_stat   = wr_ok && paddr == SFT_OFF_STATUS;
    wire rd_istat  = rd_ok && paddr == SFT_OFF_IRQSTAT;
    wire gm        = mode_r[SFT_BIT_GM];
    // controller may only serve tx/rx requests, never the error request
    wire dtc_go    = dtc_in.req && !dtc_ack_r && !stop_r;
    wire dtc_tx    = dtc_go && dtc_in.wr && dtc_in.addr == SFT_OFF_TXDATA && tde_r;
    wire dtc_rx    = dtc_go && !dtc_in.wr && dtc_in.addr == SFT_OFF_RXDATA && rdf_r;
    wire auto_clr  = !dtc_in.xfer_irq_disable_select && dtc_in.cnt_nz;
    wire etu_tick  = div_r == 16'(ETU_DIV / 2 - 1);
    wire [SFT_HALF_W-1:0] half_goal = gm ? SFT_HALF_W'(SFT_ETU_HALF_GM1)
                                         : SFT_HALF_W'(SFT_ETU_HALF_GM0);
    wire tx_end_flag_hit  = tx_end_flag_run_r && etu_tick && half_r == half_goal - 1'b1;
    wire tx_end_flag_set  = tx_end_flag_hit && tde_r && !ers_r;
    wire [7:0] status_v = {tde_r, rdf_r, orer_r, ers_r, 1'b0, tx_end_flag_r, 2'b00};
    wire [3:0] ev   = {tx_end_flag_set, rx_error, rx_char_done, tx_char_done};

    logic [7:0] rd_mux;
    always_comb begin
        case (paddr)
            SFT_OFF_TXDATA:  rd_mux = tx_data_reg_r;
            SFT_OFF_RXDATA:  rd_mux = rx_data_reg_r;
            SFT_OFF_STATUS:  rd_mux = status_v;
            SFT_OFF_MODE:    rd_mux = mode_r;
            SFT_OFF_CTRL:    rd_mux = ctrl_r;
            SFT_OFF_IRQSTAT: rd_mux = {4'h0, irq_stat_r};
            SFT_OFF_IRQMASK: rd_mux = {4'h0, irq_mask_r};
            SFT_OFF_STOP:    rd_mux = {7'h00, stop_r};
            default:         rd_mux = 8'h00;
        endcase
    end

    // ====================================================================
    // apb handshake: no wait states, errors on unmapped or stopped access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && (!known || blocked);
            if (setup) begin
                prdata_r <= (known && !blocked) ? {24'h000000, rd_mux} : 32'h0000_0000;
            end
        end
    end

    // ====================================================================
    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r     <= SFT_MODE_RST;
            ctrl_r     <= SFT_CTRL_RST;
            irq_mask_r <= 4'h0;
            stop_r     <= SFT_STOP_RST;
        end else if (wr_ok) begin
            if (paddr == SFT_OFF_MODE)    mode_r     <= pwdata[7:0];
            if (paddr == SFT_OFF_CTRL)    ctrl_r     <= pwdata[7:0];
            if (paddr == SFT_OFF_IRQMASK) irq_mask_r <= pwdata[3:0];
            if (stop_sel)                 stop_r     <= pwdata[0];
        end
    end

    // ====================================================================
    // next values of the flags; hardware set wins over a clear in the same cycle
    wire        dtc_tx_clr   = dtc_tx && auto_clr;
    wire        dtc_rx_clr   = dtc_rx && auto_clr;
    wire        tde_sw_clr   = wr_stat && !pwdata[SFT_BIT_TDE];
    wire        rdf_sw_clr   = wr_stat && !pwdata[SFT_BIT_RDF];
    wire        orer_sw_clr  = wr_stat && !pwdata[SFT_BIT_ORER];
    wire        ers_sw_clr   = wr_stat && !pwdata[SFT_BIT_ERS];
    wire        tx_end_flag_clr     = (wr_stat && !pwdata[SFT_BIT_TX_END_FLAG]) || dtc_tx;
    wire        tde_nxt      = tx_char_done || (tde_r && !(dtc_tx_clr || tde_sw_clr));
    wire        rdf_nxt      = rx_char_done || (rdf_r && !(dtc_rx_clr || rdf_sw_clr));
    wire        orer_nxt     = rx_error || (orer_r && !orer_sw_clr);
    wire        ers_nxt      = err_s2_r || (ers_r && !ers_sw_clr);
    wire        tx_end_flag_nxt     = tx_end_flag_set || (tx_end_flag_r && !tx_end_flag_clr);
    // a byte arriving while the last is unread leaves the held byte alone
    wire        rx_load      = rx_char_done && !rdf_r;
    // the controller data path is not modelled: its write reloads the held byte
    wire        tx_load      = wr_tdr || dtc_tx;
    wire [7:0]  tx_data_nxt  = wr_tdr ? pwdata[7:0] : tx_data_reg_r;
    wire [3:0]  irq_stat_nxt = ev | (rd_istat ? 4'h0 : irq_stat_r);
    wire        irq_nxt      = |(irq_stat_r & irq_mask_r);
    // divider restarts at the end of the last data bit so the delay is aligned
    wire [15:0] div_nxt      = (etu_tick || tx_char_done) ? 16'h0000 : div_r + 16'h0001;

    // ====================================================================
    // data registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_reg_r <= 8'h00;
        end else if (tx_load) begin
            tx_data_reg_r <= tx_data_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid_r <= 1'b0;
        end else begin
            tx_valid_r <= tx_load;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_reg_r <= 8'h00;
        end else if (rx_load) begin
            rx_data_reg_r <= rx_char;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dtc_ack_r <= 1'b0;
        end else begin
            dtc_ack_r <= dtc_tx || dtc_rx;
        end
    end

    // ====================================================================
    // status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tde_r <= SFT_STATUS_RST[SFT_BIT_TDE];
        end else begin
            tde_r <= tde_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdf_r <= 1'b0;
        end else begin
            rdf_r <= rdf_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            orer_r <= 1'b0;
        end else begin
            orer_r <= orer_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_end_flag_r <= SFT_STATUS_RST[SFT_BIT_TX_END_FLAG];
        end else begin
            tx_end_flag_r <= tx_end_flag_nxt;
        end
    end

    // ====================================================================
    // error-signal synchroniser: only the second stage is read by logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_s1_r <= 1'b0;
            err_s2_r <= 1'b0;
        end else begin
            err_s1_r <= error_signal_in;
            err_s2_r <= err_s1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ers_r <= 1'b0;
        end else begin
            ers_r <= ers_nxt;
        end
    end

    // ====================================================================
    // half-etu counter: delay starts at the end of the last data bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_nxt;
        end
    end

    // a new character restarts the delay, so back-to-back bytes give one end flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_r     <= '0;
            tx_end_flag_run_r <= 1'b0;
        end else if (tx_char_done) begin
            half_r     <= '0;
            tx_end_flag_run_r <= 1'b1;
        end else if (tx_end_flag_run_r && etu_tick) begin
            half_r     <= half_r + 1'b1;
            tx_end_flag_run_r <= !tx_end_flag_hit;
        end
    end

    // ====================================================================
    // interrupts: sticky status, cleared by reading it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 4'h0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // registered so the pin never glitches while status and mask settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // ====================================================================
    // outputs

    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign dtc_ack       = dtc_ack_r;
    assign tx_data_valid = tx_valid_r;
    assign tx_data_out   = tx_data_reg_r;
    assign tx_empty_irq  = tde_r;
    assign rx_full_irq   = rdf_r;
    assign rx_error_irq  = orer_r;
    assign dtc_req_tx    = tde_r;
    assign dtc_req_rx    = rdf_r;
    assign irq           = irq_r;
endmodule : sft_flags

/* tb/sft_asserts.sv */
// port checker for the serial flag logic
module sft_asserts
    import sft_pkg::*;
(
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready, pslverr, dtc_ack, tx_char_done, rx_char_done,
    input wire logic        rx_error, tx_empty_irq, rx_full_irq, dtc_req_rx, irq,
    input wire logic        tx_data_valid, rx_error_irq,
    input wire sft_dtc_s    dtc_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // helpers
    logic stop_r;
    wire acc   = psel && penable && pready;
    wire st_wr = psel && pwrite && paddr == SFT_OFF_STATUS;
    wire tk_tx = dtc_in.req && dtc_in.wr && tx_empty_irq;
    wire tk_rx = dtc_in.req && !dtc_in.wr && rx_full_irq;
    wire clr   = !dtc_in.xfer_irq_disable_select && dtc_in.cnt_nz;
    // only a served write to the stop bit reopens the registers
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) stop_r <= SFT_STOP_RST;
        else if (acc && pwrite && paddr == SFT_OFF_STOP) stop_r <= pwdata[0];
    // ==========
    // assertions
    AST_PREADY: assert property (psel && !penable |=> pready)
        else $error("late pready");
    AST_STOPPED: assert property (acc && stop_r && paddr != SFT_OFF_STOP |-> pslverr)
        else $error("access while stopped");
    AST_TX_CLR: assert property (tk_tx && clr && !tx_char_done |=> dtc_ack && !tx_empty_irq)
        else $error("tx flag kept");
    AST_RX_CLR: assert property (tk_rx && clr && !rx_char_done |=> dtc_ack && !rx_full_irq)
        else $error("rx flag kept");
    AST_KEEP: assert property (tk_tx && !clr && !st_wr |=> tx_empty_irq)
        else $error("tx flag cleared");
    AST_ACK: assert property ($rose(dtc_ack) |-> $past(tk_tx || tk_rx))
        else $error("ack without request");
    AST_ERI: assert property (rx_error && !rx_full_irq && !rx_char_done |=> !dtc_req_rx)
        else $error("error started transfer");
    AST_TDE: assert property (tx_char_done |=> tx_empty_irq)
        else $error("tx flag not set");
    AST_RDF: assert property (rx_char_done |=> rx_full_irq && dtc_req_rx)
        else $error("rx flag not set");
    AST_TXV: assert property (acc && pwrite && paddr == SFT_OFF_TXDATA && !stop_r |=> tx_data_valid)
        else $error("tx data not handed on");
    AST_ORER: assert property (rx_error |=> rx_error_irq)
        else $error("error flag not set");
    C_ACK: cover property (dtc_ack);
    C_IRQ: cover property ($rose(irq));
    C_ERR: cover property (pslverr);
endmodule : sft_asserts

bind sft_flags sft_asserts sft_asserts_inst (.*);

/* tb/sft_dtc_model.sv */
// behavioural transfer controller facing the flag logic
module sft_dtc_model
    import sft_pkg::*;
(
    input  wire logic pclk,
    input  wire logic dtc_ack,
    input  wire logic dtc_req_tx,
    input  wire logic dtc_req_rx,
    output sft_dtc_s  dtc_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial dtc_in = '0;
    task automatic xfer(input logic wr, input logic dis, input logic nz, output logic acked);
        int n;
        n = 0;
        // started by a data request only, never by the error request
        // levels are looked at on the falling edge, away from the edge that moves them
        do begin
            @(negedge pclk);
            n++;
        end while ((wr ? dtc_req_tx : dtc_req_rx) !== 1'b1 && n < 50);
        @(posedge pclk);
        // disable select and counter as set up by software
        dtc_in <= '{1'b1, dis, nz, wr, wr ? SFT_OFF_TXDATA : SFT_OFF_RXDATA};
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (dtc_ack !== 1'b1 && n < 20);
        acked = dtc_ack;
        @(posedge pclk);
        // idle bus shows no stale request fields
        dtc_in <= '{1'b0, ~dis, ~nz, ~wr, 8'hff};
    endtask : xfer
endmodule : sft_dtc_model

/* tb/sft_flags_tb.sv */
// self-checking bench for the serial flag logic
module sft_flags_tb
    import sft_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ETU = 8;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        tx_char_done = 0, rx_char_done = 0, rx_error = 0, error_signal_in = 0;
    logic [7:0]  paddr = '0, rx_char = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic        pready, pslverr, dtc_ack, tx_empty_irq, rx_full_irq, dtc_req_tx;
    logic        dtc_req_rx, irq, e, ack, tx_data_valid, rx_error_irq;
    logic [7:0]  tx_data_out;
    sft_dtc_s    dtc_in;
    int          n_fail = 0, checked = 0;
    always #10ns pclk = ~pclk;
    sft_flags #(.ETU_DIV(ETU)) sft_flags_inst (.*);
    sft_dtc_model sft_dtc_model_inst (.*);
    // ==========
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // pready is looked at mid-cycle; the next rising edge is the access edge
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) chk(pready, 1);
        r = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    task automatic pulse_tx;
        tx_char_done <= 1;
        @(posedge pclk);
        tx_char_done <= 0;
    endtask : pulse_tx
    task automatic end_of_test;
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // ==========
    // scenarios
    task automatic t_stop;
        apb(0, SFT_OFF_STATUS, 0);
        chk({r[31:1], e}, 1);
        apb(1, SFT_OFF_STOP, 0);
        apb(0, SFT_OFF_STATUS, 0);
        chk({r[7:0], e}, {SFT_STATUS_RST, 1'b0});
        apb(1, SFT_OFF_TXDATA, 32'h3c);
        chk(tx_data_out, 8'h3c);
        apb(0, 8'h20, 0);
        chk(e, 1);
    endtask : t_stop
    task automatic t_dtc_tx;
        sft_dtc_model_inst.xfer(1, 1, 1, ack);
        chk({ack, tx_empty_irq}, 2'b11);
        sft_dtc_model_inst.xfer(1, 0, 0, ack);
        chk(tx_empty_irq, 1);
        sft_dtc_model_inst.xfer(1, 0, 1, ack);
        apb(0, SFT_OFF_STATUS, 0);
        chk({ack, r[7:0]}, 9'h100);
        pulse_tx();
        apb(1, SFT_OFF_STATUS, 32'h7f);
        @(posedge pclk);
        chk(tx_empty_irq, 0);
    endtask : t_dtc_tx
    task automatic t_dtc_rx;
        rx_error <= 1;
        @(posedge pclk);
        rx_error <= 0;
        @(posedge pclk);
        chk(dtc_req_rx, 0);
        chk(rx_error_irq, 1);
        rx_char <= 8'h5a;
        rx_char_done <= 1;
        @(posedge pclk);
        rx_char_done <= 0;
        sft_dtc_model_inst.xfer(0, 0, 1, ack);
        apb(0, SFT_OFF_STATUS, 0);
        chk({ack, r[6]}, 2'b10);
        apb(0, SFT_OFF_RXDATA, 0);
        chk(r[7:0], 8'h5a);
    endtask : t_dtc_rx
    // third pass holds the error signal, so no end flag may appear
    task automatic t_tx_end_flag;
        int n;
        int x;
        apb(1, SFT_OFF_IRQMASK, 32'h8);
        apb(1, SFT_OFF_CTRL, 32'h1);
        apb(0, SFT_OFF_CTRL, 0);
        chk(r[1:0], 2'b01);
        for (int g = 0; g < 3; g++) begin
            error_signal_in <= (g == 2);
            apb(1, SFT_OFF_MODE, (g == 1) ? 32'h80 : 32'h0);
            apb(1, SFT_OFF_STATUS, 32'hfb);
            apb(0, SFT_OFF_IRQSTAT, 0);
            pulse_tx();
            n = 0;
            x = ((g == 1) ? SFT_ETU_HALF_GM1 : SFT_ETU_HALF_GM0) * (ETU / 2);
            while (irq !== 1'b1 && n < 150) begin
                @(negedge pclk);
                n++;
            end
            @(posedge pclk);
            if (g == 2) chk(n, 150);
            else chk(n >= x - 1 && n <= x + 3, 1);
            apb(0, SFT_OFF_IRQSTAT, 0);
            chk(r[3], g != 2);
            repeat (2) @(posedge pclk);
            chk(irq, 0);
        end
    endtask : t_tx_end_flag
    // ==========
    // main sequence and watchdog
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_stop();
        t_dtc_tx();
        t_dtc_rx();
        t_tx_end_flag();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end
endmodule : sft_flags_tb
